/* File: hdl/temp_corr_pkg.sv */
// constants for the temperature correction datapath
// shared by the datapath top and its multiply step module
package temp_corr_pkg;
  localparam int RAW_W = 14;
  localparam int COEF_W = 16;
  localparam int RES_W = 16;
  localparam logic [RAW_W-1:0] RAW_MAX = 14'h3FFF;
  localparam logic signed [RES_W-1:0] RES_MAX = 16'sh7FFF;
  localparam logic signed [RES_W-1:0] RES_MIN = 16'sh8000;
  localparam int ACC_W = 50;
  localparam logic [1:0] STEP_LAST = 2'h2;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_MUL = 2'b01,
    ST_DONE = 2'b11
  } corr_state_t;
endpackage : temp_corr_pkg

/* File: hdl/temp_corr_mul.sv */
// signed multiplier stage with one register
// assumes operands held stable by the caller's state machine
`timescale 1ns/100ps
module temp_corr_mul
  import temp_corr_pkg::*;
#(
  parameter int A_W = 34,
  parameter int B_W = 16
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operands
  input wire logic signed [A_W-1:0] a_i,
  input wire logic signed [B_W-1:0] b_i,
  // registered product
  output logic signed [A_W+B_W-1:0] p_o
);
  typedef struct packed
  {
    logic signed [A_W+B_W-1:0] p;
  } mul_state_t;

  mul_state_t s_q;
  mul_state_t s_d;

  if (A_W < 2 || B_W < 2)
  begin : g_width_check
    $error("multiplier operands need at least two bits each");
  end

  always_comb
  begin
    s_d = s_q;
    s_d.p = a_i * b_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign p_o = s_q.p;
endmodule : temp_corr_mul

/* File: hdl/temp_corr_datapath.sv */
// corrected temperature = sq*raw^2 + gain*raw + offset, saturated
// assumes raw code and coefficients come from logic on SYS_CLK_I
`timescale 1ns/100ps
module temp_corr_datapath
  import temp_corr_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // raw code from the conversion front end
  input wire logic START_I,
  input wire logic [RAW_W-1:0] RAW_I,
  // calibration coefficients
  input wire logic signed [COEF_W-1:0] GAIN_COEF_I,
  input wire logic signed [COEF_W-1:0] OFFSET_COEF_I,
  input wire logic signed [COEF_W-1:0] TEMP_SQUARE_COEF_I,
  // result to the conditioning processor
  output logic BUSY_O,
  output logic VALID_O,
  output logic SATURATED_O,
  output logic signed [RES_W-1:0] RESULT_O
);
  localparam int A_W = ACC_W - COEF_W;

  // step 0 squares raw through the coefficient port, so widths are tied
  if (COEF_W != RAW_W + 2 || ACC_W < COEF_W + 2 * RAW_W + 2
    || RES_W > ACC_W)
  begin : g_width_check
    $error("accumulator or operand widths too narrow for the polynomial");
  end

  typedef struct packed
  {
    corr_state_t st;
    logic [1:0] step;
    logic [RAW_W-1:0] raw;
    logic signed [COEF_W-1:0] gain;
    logic signed [COEF_W-1:0] sq;
    logic signed [ACC_W-1:0] acc;
    logic busy;
    logic valid;
    logic sat;
    logic signed [RES_W-1:0] res;
  } dp_state_t;

  dp_state_t s_q;
  dp_state_t s_d;
  logic signed [A_W-1:0] mul_a;
  logic signed [COEF_W-1:0] mul_b;
  logic signed [ACC_W-1:0] prod;
  logic signed [ACC_W-1:0] sum;

  // one shared multiplier: three cycles of latency traded for area
  temp_corr_mul #(
    .A_W(A_W),
    .B_W(COEF_W)
  ) u_mul (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .a_i(mul_a),
    .b_i(mul_b),
    .p_o(prod)
  );

  always_comb
  begin
    mul_a = '0;
    mul_b = '0;
    // raw zero-extended, coefficients signed
    if (s_q.step == 2'h0)
    begin
      mul_a = A_W'($signed({1'b0, s_q.raw}));
      mul_b = $signed({2'b00, s_q.raw});
    end
    else if (s_q.step == 2'h1)
    begin
      mul_a = prod[A_W-1:0];
      mul_b = s_q.sq;
    end
    else
    begin
      mul_a = A_W'($signed({1'b0, s_q.raw}));
      mul_b = s_q.gain;
    end
  end

  // full-width sum of both products and the offset
  assign sum = s_q.acc + prod;

  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        if (START_I)
        begin
          s_d.st = ST_MUL;
          s_d.step = 2'h0;
          s_d.raw = RAW_I;
          s_d.gain = GAIN_COEF_I;
          s_d.busy = 1'b1;
          s_d.sq = TEMP_SQUARE_COEF_I;
          s_d.acc = ACC_W'(OFFSET_COEF_I);
        end
      end
      ST_MUL:
      begin
        // step 0 builds raw^2, step 1 sq*raw^2, step 2 gain*raw
        if (s_q.step == STEP_LAST)
        begin
          s_d.acc = sum;
        end
        if (s_q.step == STEP_LAST + 2'h1)
        begin
          s_d.st = ST_DONE;
          s_d.acc = sum;
        end
        else
        begin
          s_d.step = s_q.step + 2'h1;
        end
      end
      ST_DONE:
      begin
        // clamp instead of wrapping
        if (s_q.acc > ACC_W'(RES_MAX))
        begin
          s_d.res = RES_MAX;
          s_d.sat = 1'b1;
        end
        else if (s_q.acc < ACC_W'(RES_MIN))
        begin
          s_d.res = RES_MIN;
          s_d.sat = 1'b1;
        end
        else
        begin
          s_d.res = s_q.acc[RES_W-1:0];
          s_d.sat = 1'b0;
        end
        s_d.valid = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = ST_IDLE;
      end
      default:
      begin
        s_d.busy = 1'b0;
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // flopped copy, so the output never glitches on a state decode
  assign BUSY_O = s_q.busy;
  assign VALID_O = s_q.valid;
  assign SATURATED_O = s_q.sat;
  assign RESULT_O = s_q.res;

  // assertions
  logic signed [ACC_W-1:0] ref_val;
  logic signed [ACC_W-1:0] ref_q;
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ref_q <= '0;
    end
    else if (START_I && s_q.st == ST_IDLE)
    begin
      ref_q <= ref_val;
    end
  end
  assign ref_val = ACC_W'(TEMP_SQUARE_COEF_I) * ACC_W'({1'b0, RAW_I})
    * ACC_W'({1'b0, RAW_I}) + ACC_W'(GAIN_COEF_I) * ACC_W'({1'b0, RAW_I})
    + ACC_W'(OFFSET_COEF_I);

  sequence start_s;
    START_I && s_q.st == ST_IDLE;
  endsequence

  result_timing_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    start_s |-> ##6 VALID_O)
    else $error("result not valid six cycles after start");
  poly_value_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    start_s ##6 (ref_q <= ACC_W'(RES_MAX) && ref_q >= ACC_W'(RES_MIN))
    |-> ACC_W'(RESULT_O) == ref_q && !SATURATED_O)
    else $error("corrected value mismatch");
  sat_high_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    start_s ##6 (ref_q > ACC_W'(RES_MAX)) |-> RESULT_O == RES_MAX
    && SATURATED_O)
    else $error("positive overflow not clamped");
  sat_low_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    start_s ##6 (ref_q < ACC_W'(RES_MIN)) |-> RESULT_O == RES_MIN
    && SATURATED_O)
    else $error("negative overflow not clamped");
  offset_only_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (start_s and (RAW_I == '0))
    |-> ##6 (RESULT_O == $past(OFFSET_COEF_I, 6)))
    else $error("offset not passed at zero raw");
  square_sign_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (start_s and (RAW_I == RAW_MAX && GAIN_COEF_I == '0
    && TEMP_SQUARE_COEF_I == 16'sh8000))
    |-> ##6 (RESULT_O == RES_MIN))
    else $error("square term sign wrong");
  busy_hold_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    start_s |=> BUSY_O [*5])
    else $error("busy dropped mid computation");
endmodule : temp_corr_datapath

/* File: sim/temp_corr_datapath_bench.sv */
// self-checking bench for the temperature correction datapath
// assumes the START/BUSY/VALID handshake; valid five edges after start
`timescale 1ns/100ps
module temp_corr_datapath_bench;
  import temp_corr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [RAW_W-1:0] raw = 14'h0000;
  logic signed [COEF_W-1:0] gain = 16'sh0000;
  logic signed [COEF_W-1:0] offs = 16'sh0000;
  logic signed [COEF_W-1:0] sq = 16'sh0000;
  logic busy;
  logic valid;
  logic sat;
  logic signed [RES_W-1:0] res;
  int n_errors = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  temp_corr_datapath i_temp_corr_datapath (
    .SYS_CLK_I(clk), .RST_I(rst), .START_I(start), .RAW_I(raw),
    .GAIN_COEF_I(gain), .OFFSET_COEF_I(offs), .TEMP_SQUARE_COEF_I(sq),
    .BUSY_O(busy), .VALID_O(valid), .SATURATED_O(sat), .RESULT_O(res)
  );

  task automatic print_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic go(input logic [13:0] r, input logic [15:0] g, o, s);
    raw = r;
    gain = g;
    offs = o;
    sq = s;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
  endtask : go

  // poke: a second start while busy, which must be ignored
  task automatic run(input logic [13:0] r, input logic [15:0] g, o, s,
                     input bit poke);
    longint e;
    int n;
    logic x;
    e = longint'(signed'(s)) * r * r + longint'(signed'(g)) * r;
    e = e + longint'(signed'(o));
    x = (e > 32767) || (e < -32768);
    e = (e > 32767) ? 32767 : ((e < -32768) ? -32768 : e);
    go(r, g, o, s);
    chk("busy", {15'h0000, busy}, 16'h0001);
    n = 0;
    if (poke)
    begin
      // let an edge pass so start is never dropped and raised in one step
      @(posedge clk);
      #1 go(~r, ~g, ~o, ~s);
      n = 2;
    end
    while (valid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20)
    begin
      n_errors++;
      print_verdict();
    end
    chk("latency", n[15:0], 16'h0005);
    chk("result", res, e[15:0]);
    chk("saturated", {15'h0000, sat}, {15'h0000, x});
    chk("busy_end", {15'h0000, busy}, 16'h0000);
  endtask : run

  task automatic refuse_check;
    run(14'h0005, 16'sh0003, 16'sh0002, 16'sh0001, 1'b1);
    repeat (8)
    begin
      @(posedge clk);
      #1 chk("no_extra", {15'h0000, valid}, 16'h0000);
    end
  endtask : refuse_check

  task automatic reset_mid_run;
    go(14'h0010, 16'sh0100, 16'sh0000, 16'sh0000);
    repeat (2) @(posedge clk);
    #1 rst = 1'b1;
    #10 chk("rst_res", res, 16'h0000);
    chk("rst_flags", {13'h0000, busy, valid, sat}, 16'h0000);
    @(posedge clk);
    #1 rst = 1'b0;
    run(14'h0010, 16'sh0100, 16'sh0000, 16'sh0000, 1'b0);
  endtask : reset_mid_run

  initial
  begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    // drift limits are the calibrator's; no drift input here
    // so stimulus only keeps coefficients in 16-bit range
    // consecutive runs start in the valid cycle: back-to-back
    run(14'h0064, 16'sh0100, 16'sh0010, 16'sh0000, 1'b0);
    run(14'h3FFF, 16'sh0001, 16'shFFFF, 16'sh0000, 1'b0);
    run(14'h0002, 16'sh8000, 16'sh7FFF, 16'sh0001, 1'b0);
    run(14'h0003, 16'sh0000, 16'sh8000, 16'shFFFF, 1'b0);
    run(14'h3FFF, 16'sh0000, 16'sh0000, 16'sh7FFF, 1'b0);
    run(14'h3FFF, 16'sh7FFF, 16'sh7FFF, 16'sh8000, 1'b0);
    run(14'h0000, 16'sh7FFF, 16'sh8000, 16'sh7FFF, 1'b0);
    run(14'h00B5, 16'sh0000, 16'sh0006, 16'sh0001, 1'b0);
    run(14'h00B5, 16'sh0000, 16'sh0007, 16'sh0001, 1'b0);
    run(14'h3FFF, 16'sh0000, 16'sh1234, 16'sh8000, 1'b0);
    refuse_check();
    reset_mid_run();
    print_verdict();
  end
endmodule : temp_corr_datapath_bench
